// >>> sts_threshold_status.sv
// Threshold sector and return-status interpreter for the reliability commands
//
// Operation
// - Threshold read returns 512 bytes: version 0004h, thirty entries, zeros, checksum.
// - Entry C4h carries spare-block threshold at byte 1; bytes 2-11 zero.
// - Entry E5h carries erase-count threshold at byte 1; rest zero.
// - Entry CBh, total ECC errors, has zero threshold and zero tail.
// - Entry CCh, correctable ECC errors, has zero threshold and tail.
// - Entry E8h, flash read count, has zero threshold and tail.
// - Entry C7h, interface CRC errors, has zero threshold and tail.
// - Status check with exceeded condition loads F4h low, 2Ch high.
// - Status check without exceeded condition loads 4Fh low, C2h high.
// - Only spare-block and erase-count attributes affect the status check.
// - Spare value below spare threshold means exceeded.
// - Remaining-life percentage below erase threshold means exceeded.
// - Spare value is minimum over chips of 100*current/initial spares.
`timescale 1ns/10ps
`include "sts_cfg.svh"
module sts_threshold_status
    import sts_pkg::*;
#(
    parameter int CHIPS      = 4,
    parameter int CW         = 16,
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset
    input  wire logic                clk_in,
    input  wire logic                reset_in,
    // Command from the task file
    input  wire logic                cmd_valid_in,
    input  wire sts_cmd_t            cmd_in,
    output logic                     busy_out,
    output logic                     cmd_abort_out,
    // Stored thresholds
    input  wire logic [7:0]          spare_thresh_in,
    input  wire logic [7:0]          erase_thresh_in,
    // Attribute sources
    input  wire logic [CHIPS*CW-1:0] chip_cur_spare_in,
    input  wire logic [CHIPS*CW-1:0] chip_init_spare_in,
    input  wire logic [7:0]          erase_life_in,
    // Sector byte stream
    output logic                     data_valid_out,
    input  wire logic                data_ready_in,
    output logic [7:0]               data_out,
    output logic                     data_last_out,
    // Status check result
    output logic                     status_valid_out,
    output sts_cyl_t                 cyl_out,
    output logic                     exceeded_out
);
    // ----------------------------------------------------------------
    // Sector byte generator
    // ----------------------------------------------------------------
    function automatic logic [7:0] sector_byte(input logic [8:0] idx,
                                               input logic [7:0] spare_thr,
                                               input logic [7:0] erase_thr);
        logic [8:0] rel;
        logic [8:0] ent;
        logic [8:0] off;
        logic [7:0] id;
        logic [7:0] thr;
        logic [15:0] ver;
        ver = `STS_VERSION;
        rel = idx - `STS_ENTRY_FIRST;
        ent = rel / `STS_ENTRY_BYTES;
        off = rel % `STS_ENTRY_BYTES;
        id  = 8'h00;
        thr = 8'h00;
        unique case (ent)
            9'h000: begin id = `STS_ID_SPARE;     thr = spare_thr; end
            9'h001: begin id = `STS_ID_ERASE;     thr = erase_thr; end
            9'h002: id = `STS_ID_ECC_TOTAL;
            9'h003: id = `STS_ID_ECC_CORR;
            9'h004: id = `STS_ID_READS;
            9'h005: id = `STS_ID_CRC;
            default: id = 8'h00;
        endcase
        if (idx == 9'h000) return ver[7:0];
        if (idx == 9'h001) return ver[15:8];
        if (idx < `STS_ENTRY_FIRST || idx >= `STS_ENTRY_END) return 8'h00;
        if (off == 9'h000) return id;
        if (off == `STS_ENTRY_IDX_THR) return thr;
        return 8'h00;
    endfunction : sector_byte

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    sts_state_t state_q;
    sts_state_t state_d;
    logic [8:0] idx_q;
    logic [7:0] sum_q;
    logic [7:0] spare_thr_q;
    logic [7:0] erase_thr_q;
    logic       status_valid_q;
    sts_cyl_t   cyl_q;
    logic       exceeded_q;
    logic       abort_q;

    wire idle     = (state_q == STS_IDLE);
    wire sig_ok   = (cmd_in.cyl_lo == `STS_SIG_LO) && (cmd_in.cyl_hi == `STS_SIG_HI);
    wire is_cmd   = cmd_valid_in && idle && (cmd_in.command == `STS_CMD_CODE);
    wire take_thr = is_cmd && sig_ok && (cmd_in.features == `STS_SUB_THRESH);
    wire take_sts = is_cmd && sig_ok && (cmd_in.features == `STS_SUB_STATUS);
    wire bad_cmd  = cmd_valid_in && idle && !take_thr && !take_sts;

    // ----------------------------------------------------------------
    // Attribute evaluation
    // ----------------------------------------------------------------
    logic [7:0] spare_val;

    sts_spare_min #(
        .CHIPS (CHIPS),
        .CW    (CW)
    ) u_spare (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .cur_in    (chip_cur_spare_in),
        .init_in   (chip_init_spare_in),
        .value_out (spare_val),
        .done_out  ()
    );

    wire spare_exc = spare_val < spare_thresh_in;
    wire erase_exc = erase_life_in < erase_thresh_in;
    // Error and read counters never enter this term
    wire exceeded  = spare_exc || erase_exc;

    // ----------------------------------------------------------------
    // Sector stream into FIFO
    // ----------------------------------------------------------------
    logic      fifo_ready;
    sts_byte_t push_byte;
    sts_byte_t pop_byte;

    wire       sending  = (state_q == STS_SEND);
    wire       push     = sending && fifo_ready;
    wire       last_idx = (idx_q == `STS_SECTOR_LAST);
    wire [7:0] gen_byte = sector_byte(idx_q, spare_thr_q, erase_thr_q);
    wire [7:0] chk_byte = 8'h00 - sum_q;

    assign push_byte.data = last_idx ? chk_byte : gen_byte;
    assign push_byte.last = last_idx;

    sts_fifo #(
        .WIDTH ($bits(sts_byte_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .in_valid_in   (sending),
        .in_ready_out  (fifo_ready),
        .in_data_in    (push_byte),
        .out_valid_out (data_valid_out),
        .out_ready_in  (data_ready_in),
        .out_data_out  (pop_byte)
    );

    assign data_out      = pop_byte.data;
    assign data_last_out = pop_byte.last;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            STS_IDLE: if (take_thr) state_d = STS_SEND;
            STS_SEND: if (push && last_idx) state_d = STS_IDLE;
            default:  state_d = STS_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state_q <= STS_IDLE;
            idx_q   <= 9'h000;
            sum_q   <= 8'h00;
        end else begin
            state_q <= state_d;
            if (take_thr) begin
                idx_q <= 9'h000;
                sum_q <= 8'h00;
            end else if (push) begin
                idx_q <= idx_q + 9'h001;
                sum_q <= sum_q + push_byte.data;
            end
        end
    end

    // Thresholds frozen for the whole sector so the checksum stays valid
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            spare_thr_q <= 8'h00;
            erase_thr_q <= 8'h00;
        end else if (take_thr) begin
            spare_thr_q <= spare_thresh_in;
            erase_thr_q <= erase_thresh_in;
        end
    end

    // ----------------------------------------------------------------
    // Status check result
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            status_valid_q <= 1'b0;
            abort_q        <= 1'b0;
            exceeded_q     <= 1'b0;
            cyl_q.lo       <= `STS_SIG_LO;
            cyl_q.hi       <= `STS_SIG_HI;
        end else begin
            status_valid_q <= take_sts;
            abort_q        <= bad_cmd;
            if (take_sts) begin
                exceeded_q <= exceeded;
                cyl_q.lo   <= exceeded ? `STS_FAIL_LO : `STS_SIG_LO;
                cyl_q.hi   <= exceeded ? `STS_FAIL_HI : `STS_SIG_HI;
            end
        end
    end

    assign status_valid_out = status_valid_q;
    assign cyl_out          = cyl_q;
    assign exceeded_out     = exceeded_q;
    assign cmd_abort_out    = abort_q;
    assign busy_out         = !idle;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_version;
        @(posedge clk_in) disable iff (reset_in)
        push && idx_q == 9'h000 |-> push_byte.data == 8'h04 ##1 push_byte.data == 8'h00 || !push;
    endproperty
    a_version: assert property (p_version) else $error("version bytes wrong");

    property p_sector_length;
        @(posedge clk_in) disable iff (reset_in)
        push && push_byte.last |-> idx_q == 9'h1FF ##1 state_q == STS_IDLE;
    endproperty
    a_sector_length: assert property (p_sector_length) else $error("sector not 512 bytes");

    property p_reserved_zero;
        @(posedge clk_in) disable iff (reset_in)
        push && idx_q >= 9'h16A && idx_q < 9'h1FF |-> push_byte.data == 8'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved byte not zero");

    property p_spare_entry;
        @(posedge clk_in) disable iff (reset_in)
        push && idx_q == 9'h002 |-> push_byte.data == 8'hC4 ##1 (!push || push_byte.data == spare_thr_q);
    endproperty
    a_spare_entry: assert property (p_spare_entry) else $error("spare entry wrong");

    property p_spare_tail;
        @(posedge clk_in) disable iff (reset_in)
        push && idx_q >= 9'h004 && idx_q <= 9'h00D |-> push_byte.data == 8'h00;
    endproperty
    a_spare_tail: assert property (p_spare_tail) else $error("spare entry tail not zero");

    property p_erase_entry;
        @(posedge clk_in) disable iff (reset_in)
        push && idx_q == 9'h00E |-> push_byte.data == 8'hE5 ##1 (!push || push_byte.data == erase_thr_q);
    endproperty
    a_erase_entry: assert property (p_erase_entry) else $error("erase entry wrong");

    property p_ecc_total;
        @(posedge clk_in) disable iff (reset_in)
        push && idx_q == 9'h01A |-> push_byte.data == 8'hCB ##1 (!push || push_byte.data == 8'h00);
    endproperty
    a_ecc_total: assert property (p_ecc_total) else $error("total ecc entry wrong");

    property p_ecc_corr;
        @(posedge clk_in) disable iff (reset_in)
        push && idx_q == 9'h026 |-> push_byte.data == 8'hCC;
    endproperty
    a_ecc_corr: assert property (p_ecc_corr) else $error("correctable ecc entry wrong");

    property p_reads;
        @(posedge clk_in) disable iff (reset_in)
        push && idx_q == 9'h032 |-> push_byte.data == 8'hE8;
    endproperty
    a_reads: assert property (p_reads) else $error("read count entry wrong");

    property p_crc;
        @(posedge clk_in) disable iff (reset_in)
        push && idx_q == 9'h03E |-> push_byte.data == 8'hC7;
    endproperty
    a_crc: assert property (p_crc) else $error("crc entry wrong");

    property p_fail_sig;
        @(posedge clk_in) disable iff (reset_in)
        take_sts && exceeded |=> status_valid_out && cyl_out.lo == 8'hF4 && cyl_out.hi == 8'h2C;
    endproperty
    a_fail_sig: assert property (p_fail_sig) else $error("exceeded signature wrong");

    property p_pass_sig;
        @(posedge clk_in) disable iff (reset_in)
        take_sts && !exceeded |=> status_valid_out && cyl_out.lo == 8'h4F && cyl_out.hi == 8'hC2;
    endproperty
    a_pass_sig: assert property (p_pass_sig) else $error("pass signature wrong");

    property p_cause;
        @(posedge clk_in) disable iff (reset_in)
        status_valid_out |-> exceeded_out == ($past(spare_val) < $past(spare_thresh_in)
                                              || $past(erase_life_in) < $past(erase_thresh_in));
    endproperty
    a_cause: assert property (p_cause) else $error("exceeded cause wrong");

    property p_checksum;
        @(posedge clk_in) disable iff (reset_in)
        push && last_idx |-> 8'(sum_q + push_byte.data) == 8'h00;
    endproperty
    a_checksum: assert property (p_checksum) else $error("sector checksum nonzero");
endmodule : sts_threshold_status

// >>> sts_cfg.svh
// Constants for the threshold sector and return-status interpreter
`ifndef STS_CFG_SVH
`define STS_CFG_SVH

// --------------------------------------------------------------------
// Command decode
// --------------------------------------------------------------------
`define STS_CMD_CODE        8'hB0
`define STS_SUB_THRESH      8'hD1
`define STS_SUB_STATUS      8'hDA
`define STS_SIG_LO          8'h4F
`define STS_SIG_HI          8'hC2
`define STS_FAIL_LO         8'hF4
`define STS_FAIL_HI         8'h2C

// --------------------------------------------------------------------
// Sector layout
// --------------------------------------------------------------------
`define STS_VERSION         16'h0004
`define STS_SECTOR_LAST     9'h1FF
`define STS_ENTRY_FIRST     9'h002
`define STS_ENTRY_END       9'h16A
`define STS_ENTRY_BYTES     9'h00C
`define STS_ENTRY_IDX_THR   9'h001

// --------------------------------------------------------------------
// Threshold entry identifiers, in sector order
// --------------------------------------------------------------------
`define STS_ID_SPARE        8'hC4
`define STS_ID_ERASE        8'hE5
`define STS_ID_ECC_TOTAL    8'hCB
`define STS_ID_ECC_CORR     8'hCC
`define STS_ID_READS        8'hE8
`define STS_ID_CRC          8'hC7

// --------------------------------------------------------------------
// Spare percentage
// --------------------------------------------------------------------
`define STS_PCT_FULL        8'h64

`endif

// >>> sts_pkg.sv
// Types shared by the threshold sector and return-status interpreter
package sts_pkg;

    // Task file image taken with a command
    typedef struct packed {
        logic [7:0] command;
        logic [7:0] features;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
    } sts_cmd_t;

    // Cylinder pair returned by the status check
    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
    } sts_cyl_t;

    // One sector byte plus end marker
    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } sts_byte_t;

    typedef enum logic [1:0] {
        STS_IDLE = 2'b01,
        STS_SEND = 2'b10
    } sts_state_t;

endpackage : sts_pkg

// >>> sts_fifo.sv
// Small synchronous FIFO for the sector byte stream
`timescale 1ns/10ps
module sts_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire              push = in_valid_in && in_ready_out;
    wire              pop  = out_valid_out && out_ready_in;

    assign in_ready_out  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out  = mem_q[rd_q];

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= bump(wr_q);
            if (pop)  rd_q <= bump(rd_q);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) mem_q[wr_q] <= in_data_in;
    end

    property p_no_overflow;
        @(posedge clk_in) disable iff (reset_in)
        cnt_q <= (AW+1)'(DEPTH);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("fifo count above depth");
endmodule : sts_fifo

// >>> sts_spare_min.sv
// Walks the flash chips and keeps the least spare-block percentage
`timescale 1ns/10ps
`include "sts_cfg.svh"
module sts_spare_min #(
    parameter int CHIPS = 4,
    parameter int CW    = 16
) (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              reset_in,
    // Per-chip spare block counts
    input  wire logic [CHIPS*CW-1:0] cur_in,
    input  wire logic [CHIPS*CW-1:0] init_in,
    // Attribute value
    output logic [7:0]             value_out,
    output logic                   done_out
);
    localparam int IW = (CHIPS > 1) ? $clog2(CHIPS) : 1;

    logic [IW-1:0] idx_q;
    logic [7:0]    run_q;
    logic [7:0]    value_q;
    logic          done_q;

    // One shared divider; a chip with no initial spares counts as full
    function automatic logic [7:0] pct(input logic [CW-1:0] cur, input logic [CW-1:0] init);
        logic [CW+7:0] q;
        q = '0;
        if (init == '0) return `STS_PCT_FULL;
        q = ((CW+8)'(cur) * (CW+8)'(`STS_PCT_FULL)) / (CW+8)'(init);
        return (q > (CW+8)'(`STS_PCT_FULL)) ? `STS_PCT_FULL : q[7:0];
    endfunction : pct

    wire [7:0] chip_pct = pct(cur_in[idx_q*CW +: CW], init_in[idx_q*CW +: CW]);
    wire       first    = (idx_q == '0);
    wire       lastchip = (idx_q == IW'(CHIPS - 1));
    wire [7:0] run_d    = (first || chip_pct < run_q) ? chip_pct : run_q;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            idx_q   <= '0;
            run_q   <= `STS_PCT_FULL;
            value_q <= `STS_PCT_FULL;
            done_q  <= 1'b0;
        end else begin
            idx_q  <= lastchip ? '0 : idx_q + 1'b1;
            run_q  <= run_d;
            done_q <= lastchip;
            if (lastchip) value_q <= run_d;
        end
    end

    assign value_out = value_q;
    assign done_out  = done_q;

    property p_value_bounded;
        @(posedge clk_in) disable iff (reset_in)
        done_out |-> value_out <= `STS_PCT_FULL && value_out == $past(run_d);
    endproperty
    a_value_bounded: assert property (p_value_bounded) else $error("spare percentage wrong");
endmodule : sts_spare_min

// >>> sts_host_model.sv
// Host controller model: issues task file commands and drains the sector
`timescale 1ns/10ps
module sts_host_model
    import sts_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    // Command side
    output logic            cmd_valid_out,
    output sts_cmd_t        cmd_out,
    // Sector stream
    input  wire logic       data_valid_in,
    input  wire logic [7:0] data_in,
    input  wire logic       data_last_in,
    output logic            data_ready_out
);
    logic [7:0] sec       [512];
    logic       last_seen [512];
    int         got;

    initial begin
        cmd_valid_out  = 1'b0;
        cmd_out        = '1;
        data_ready_out = 1'b0;
        got            = 0;
    end

    // --------------------------------------------------------------------
    // Command issue
    // --------------------------------------------------------------------
    task automatic issue(input logic [7:0] c, input logic [7:0] f, input logic [7:0] lo, input logic [7:0] hi);
        sts_cmd_t w;
        w = '{command: c, features: f, cyl_lo: lo, cyl_hi: hi};
        @(posedge clk_in);
        cmd_valid_out <= 1'b1;
        cmd_out       <= w;
        @(posedge clk_in);
        cmd_valid_out <= 1'b0;
        // Stale task file contents never linger on the bus
        cmd_out       <= ~w;
    endtask : issue

    // --------------------------------------------------------------------
    // Sector drain, stalling stall_len of every 16 cycles to fill the FIFO
    // --------------------------------------------------------------------
    task automatic drain(input int stall_len, input int limit);
        int cyc;
        got = 0;
        cyc = 0;
        while (got < 512 && cyc < limit) begin
            @(posedge clk_in);
            if (data_valid_in && data_ready_out) begin
                sec[got]       = data_in;
                last_seen[got] = data_last_in;
                got++;
            end
            cyc++;
            data_ready_out <= ((cyc % 16) >= stall_len) && (got < 512);
        end
    endtask : drain
endmodule : sts_host_model

// >>> tb_smart_threshold_status.sv
// Self-checking testbench for the threshold sector and return-status block
`timescale 1ns/10ps
`include "sts_cfg.svh"
module tb_smart_threshold_status;
    import sts_pkg::*;
    localparam int CHIPS = 4;
    localparam int CW    = 16;
    localparam int LIMIT = 10000;
    localparam logic [7:0]  IDS  [6] = '{8'hC4, 8'hE5, 8'hCB, 8'hCC, 8'hE8, 8'hC7};
    localparam logic [15:0] CUR  [7] = '{16'h0064, 16'h0028, 16'h0032, 16'h0031, 16'h0018, 16'h0064, 16'h0064};
    localparam logic [15:0] INI  [7] = '{16'h0064, 16'h0064, 16'h0064, 16'h0062, 16'h0032, 16'h0064, 16'h0064};
    localparam logic [7:0]  LIFE [7] = '{8'h64, 8'h64, 8'h64, 8'h64, 8'h64, 8'h09, 8'h0A};
    localparam logic        EXC  [7] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

    logic                clk_in, reset_in, cmd_valid, busy, abort;
    sts_cmd_t            cmd;
    logic [7:0]          spare_thr, erase_thr, erase_life, d_data;
    logic [CHIPS*CW-1:0] cur_spare, init_spare;
    logic                d_valid, d_ready, d_last, st_valid, exceeded;
    sts_cyl_t            cyl;
    int                  mismatches, compares, cycles, st_pulses;

    sts_threshold_status #(.CHIPS(CHIPS), .CW(CW), .FIFO_DEPTH(4)) dut_u (
        .clk_in(clk_in), .reset_in(reset_in), .cmd_valid_in(cmd_valid), .cmd_in(cmd),
        .busy_out(busy), .cmd_abort_out(abort), .spare_thresh_in(spare_thr),
        .erase_thresh_in(erase_thr), .chip_cur_spare_in(cur_spare), .chip_init_spare_in(init_spare),
        .erase_life_in(erase_life), .data_valid_out(d_valid), .data_ready_in(d_ready),
        .data_out(d_data), .data_last_out(d_last), .status_valid_out(st_valid),
        .cyl_out(cyl), .exceeded_out(exceeded));

    sts_host_model host_u (
        .clk_in(clk_in), .reset_in(reset_in), .cmd_valid_out(cmd_valid), .cmd_out(cmd),
        .data_valid_in(d_valid), .data_in(d_data), .data_last_in(d_last), .data_ready_out(d_ready));

    always #2.5 clk_in = ~clk_in;

    // --------------------------------------------------------------------
    // Bookkeeping and hang guard
    // --------------------------------------------------------------------
    always @(posedge clk_in) begin
        cycles++;
        if (st_valid === 1'b1) st_pulses++;
        if (cycles >= LIMIT) begin
            mismatches++;
            conclude();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    // --------------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------------
    task automatic sc_reset();
        chk("cyl after reset", 16'h4FC2, cyl);
        chk("busy after reset", 16'h0000, {15'h0000, busy});
    endtask : sc_reset

    // Minimum over chips, an exact 49/98 ratio and both thresholds at the boundary
    task automatic sc_status();
        logic [CHIPS*CW-1:0] cv;
        logic [CHIPS*CW-1:0] iv;
        for (int n = 0; n < 7; n++) begin
            cv = {CHIPS{16'h0064}};
            iv = cv;
            cv[2*CW +: CW] = CUR[n];
            iv[2*CW +: CW] = INI[n];
            @(posedge clk_in);
            cur_spare  <= cv;
            init_spare <= iv;
            erase_life <= LIFE[n];
            // Spare walk refreshes every CHIPS cycles
            repeat (3*CHIPS) @(posedge clk_in);
            host_u.issue(`STS_CMD_CODE, `STS_SUB_STATUS, `STS_SIG_LO, `STS_SIG_HI);
            #1;
            chk("status pulse", 16'h0001, {15'h0000, st_valid});
            chk($sformatf("cyl case %0d", n), EXC[n] ? 16'hF42C : 16'h4FC2, cyl);
            chk("exceeded", {15'h0000, EXC[n]}, {15'h0000, exceeded});
        end
    endtask : sc_status

    task automatic sc_abort();
        logic [7:0] c [3];
        logic [7:0] f [3];
        logic [7:0] l [3];
        c = '{8'hEC, `STS_CMD_CODE, `STS_CMD_CODE};
        f = '{`STS_SUB_STATUS, `STS_SUB_STATUS, 8'h55};
        l = '{`STS_SIG_LO, 8'h00, `STS_SIG_LO};
        for (int n = 0; n < 3; n++) begin
            host_u.issue(c[n], f[n], l[n], `STS_SIG_HI);
            #1;
            chk($sformatf("abort %0d", n), 16'h0001, {15'h0000, abort});
            chk("no status", 16'h0000, {15'h0000, st_valid});
        end
    endtask : sc_abort

    // Full sector under heavy back-pressure, with a status request while busy
    task automatic sc_sector();
        logic [7:0] e [512];
        logic [7:0] sum;
        int         s0;
        for (int i = 0; i < 512; i++) e[i] = 8'h00;
        e[0] = 8'h04;
        for (int k = 0; k < 6; k++) e[2+12*k] = IDS[k];
        e[3]  = spare_thr;
        e[15] = erase_thr;
        sum = 8'h00;
        for (int i = 0; i < 511; i++) sum += e[i];
        e[511] = 8'h00 - sum;
        s0 = st_pulses;
        host_u.issue(`STS_CMD_CODE, `STS_SUB_THRESH, `STS_SIG_LO, `STS_SIG_HI);
        fork
            host_u.drain(8, 6000);
            begin
                repeat (20) @(posedge clk_in);
                host_u.issue(`STS_CMD_CODE, `STS_SUB_STATUS, `STS_SIG_LO, `STS_SIG_HI);
            end
        join
        chk("byte count", 16'h0200, host_u.got[15:0]);
        sum = 8'h00;
        for (int i = 0; i < 512; i++) begin
            sum += host_u.sec[i];
            chk($sformatf("byte %0d", i), {8'h00, e[i]}, {8'h00, host_u.sec[i]});
            chk($sformatf("last %0d", i), {15'h0000, i == 511}, {15'h0000, host_u.last_seen[i]});
        end
        chk("sector sum", 16'h0000, {8'h00, sum});
        chk("status while busy", s0[15:0], st_pulses[15:0]);
        repeat (4) @(posedge clk_in);
        #1;
        chk("busy after sector", 16'h0000, {15'h0000, busy});
    endtask : sc_sector

    // --------------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------------
    initial begin
        clk_in     = 1'b0;
        reset_in   = 1'b1;
        mismatches = 0;
        compares   = 0;
        cycles     = 0;
        st_pulses  = 0;
        spare_thr  = 8'h32;
        erase_thr  = 8'h0A;
        erase_life = 8'h64;
        cur_spare  = {CHIPS{16'h0064}};
        init_spare = {CHIPS{16'h0064}};
        repeat (10) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        #1;
        sc_reset();
        sc_status();
        sc_abort();
        sc_sector();
        conclude();
    end
endmodule : tb_smart_threshold_status
